// ==== rtl/ovf_fault_handler.sv ====
`timescale 1ns/100ps
// How it works
// - Threshold is word command 55h, read back.
// - Action is byte command 56h, read back.
// - Threshold exponent 15:11 reads 11110b, mantissa 10:0.
// - Input above threshold is a fault; act.
// - Accept thresholds 5-22 V, 0.25 V steps.
// - Bad threshold write flags invalid data, alerts.
// - Power cycle or restore reloads nearest step; reset here loads the 22 V default instead.
// - Fault sets none-above, input, overvoltage flags; alert.
// - Action 00b keeps running through the fault.
// - Action 01b runs delay cycles, then shuts down if the fault is still present.
// - Action 10b shuts down at once.
// - Action 11b is unsupported.
// - Restart field 0 latches off after shutdown.
// - Restart 1-6: hiccup, retry that often, latch.
// - Retries during fault still count.
// - Restart 7 retries forever until off/success.
// - Delay 0-1: three clocks, one rise time.
// - Delay 2-4: five clocks, value times rise.
// - Delay 5-7: nine clocks, value times rise.
// - Fault present at enable blocks start-up.
// - Bad action write flags invalid data, alerts.
module ovf_fault_handler (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  // Command port from the bus transaction engine
  input  wire logic                       cmd_valid,
  input  wire logic                       cmd_write,
  input  wire logic [7:0]                 cmd_code,
  input  wire logic [15:0]                cmd_data,
  output logic                            rd_valid,
  output logic [15:0]                     rd_data,
  // Converter control and measurements
  input  wire logic                       enable,
  input  wire logic                       startup_done,
  input  wire logic                       clear_faults,
  input  wire logic                       nvm_store,
  input  wire logic                       nvm_restore,
  input  wire logic                       pwm_tick,
  input  wire logic [ovf_pkg::RISE_W-1:0] soft_start_rise_time,
  input  wire logic [7:0]                 power_stage_input_voltage,
  // Power stage and status
  output logic                            power_stage_on,
  output logic                            status_none_above,
  output logic                            status_input,
  output logic                            status_vin_ov,
  output logic                            status_invalid_data,
  output logic                            host_alert
);
  import ovf_pkg::*;

  typedef struct packed {
    ovf_state_t                st;
    logic [7:0]                thr;
    logic [7:0]                nvm_thr;
    logic [7:0]                action;
    logic [2:0]                attempts;
    logic [3:0]                dly_cnt;
    logic [RISE_W-1:0]         rise_cnt;
    logic [2:0]                unit_cnt;
    logic                      none_above;
    logic                      input_flag;
    logic                      vin_ov;
    logic                      invalid;
    logic                      alert;
    logic                      power_on;
    logic                      rd_valid;
    logic [15:0]               rd_data;
  } ovf_regs_t;

  ovf_regs_t r;
  ovf_regs_t next_r;
  logic      rst_meta;
  logic      rst_sync;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Linear word to 0.25 V steps; bit 8 marks an acceptable value
  function automatic logic [8:0] ovf_to_steps(input logic [15:0] w);
    logic signed [6:0] sh;
    logic [4:0]        n;
    logic [10:0]       man;
    logic [10:0]       frac;
    logic [18:0]       wide;
    logic              bad;
    sh   = 7'(signed'(w[EXP_MSB:EXP_LSB])) + EXP_TO_STEPS;
    man  = w[MAN_MSB:0];
    n    = 5'(-sh);
    frac = 11'((12'h1 << n) - 12'h1);
    bad  = man[MAN_MSB];
    wide = 19'h0;
    if (!sh[6]) begin
      if (sh > 7'sh07) begin
        bad = bad | (man != 11'h0);
      end else begin
        wide = 19'({8'h0, man} << sh[2:0]);
      end
    end else begin
      bad  = bad | ((man & frac) != 11'h0);  // Off-step values are refused
      wide = 19'({8'h0, man} >> n);
    end
    bad = bad | (wide < 19'(STEPS_MIN)) | (wide > 19'(STEPS_MAX));
    return {~bad, wide[7:0]};
  endfunction

  logic [8:0] thr_check;
  logic [1:0] act_field;
  logic [2:0] retry_field;
  logic [2:0] dly_field;
  logic [3:0] shut_delay;
  logic [2:0] hiccup_mult;
  logic       fault;
  logic       shut_now;

  // Decoded settings and the fault comparison
  always_comb begin
    thr_check   = ovf_to_steps(cmd_data);
    act_field   = r.action[ACT_MSB:ACT_LSB];
    retry_field = r.action[RETRY_MSB:RETRY_LSB];
    dly_field   = r.action[DLY_MSB:DLY_LSB];
    fault       = power_stage_input_voltage > r.thr;
    if (dly_field >= DLY_GROUP_LONG) begin
      shut_delay = SHUT_DLY_LONG;
    end else if (dly_field >= DLY_GROUP_MID) begin
      shut_delay = SHUT_DLY_MID;
    end else begin
      shut_delay = SHUT_DLY_SHORT;
    end
    // Fields 0 and 1 both mean a single rise time
    hiccup_mult = (dly_field < DLY_GROUP_MID) ? HICCUP_MIN_MULT : dly_field;
  end

  // Next-state logic for the whole block
  always_comb begin
    next_r          = r;
    next_r.rd_valid = 1'b0;
    shut_now        = 1'b0;

    // Command accesses; refused writes leave stored values alone
    if (cmd_valid) begin
      if (cmd_code == CMD_THRESHOLD) begin
        if (cmd_write) begin
          if (thr_check[8]) begin
            next_r.thr = thr_check[7:0];
          end else begin
            next_r.invalid = 1'b1;
          end
        end else begin
          next_r.rd_valid = 1'b1;
          next_r.rd_data  = {EXP_READBACK, 3'h0, r.thr};
        end
      end else if (cmd_code == CMD_ACTION) begin
        if (cmd_write) begin
          if (cmd_data[ACT_MSB:ACT_LSB] != ACT_UNSUPPORTED) begin
            next_r.action = cmd_data[7:0];
          end else begin
            next_r.invalid = 1'b1;
          end
        end else begin
          next_r.rd_valid = 1'b1;
          next_r.rd_data  = {8'h00, r.action};
        end
      end
    end

    // Store keeps a copy; restore brings back a whole step value
    if (nvm_store) begin
      next_r.nvm_thr = r.thr;
    end
    if (nvm_restore) begin
      next_r.thr = r.nvm_thr;
    end

    // Sequencing and fault response
    unique case (r.st)
      OVF_OFF: begin
        next_r.power_on = 1'b0;
        // Fault at enable blocks start-up even in ignore mode
        if (enable && !fault) begin
          next_r.st       = OVF_START;
          next_r.attempts = 3'h0;
          next_r.power_on = 1'b1;
        end
      end
      OVF_START, OVF_RUN: begin
        if (!enable) begin
          next_r.st       = OVF_OFF;
          next_r.power_on = 1'b0;
        end else if (fault && act_field == ACT_IMMEDIATE) begin
          shut_now = 1'b1;
        end else if (fault && act_field == ACT_DELAYED) begin
          next_r.st      = OVF_DELAY;
          next_r.dly_cnt = 4'h0;
        end else if (r.st == OVF_START && startup_done) begin
          next_r.st       = OVF_RUN;
          next_r.attempts = 3'h0;
        end
        // Ignore mode falls through and keeps switching
      end
      OVF_DELAY: begin
        if (!enable) begin
          next_r.st       = OVF_OFF;
          next_r.power_on = 1'b0;
        end else if (fault && act_field == ACT_IMMEDIATE) begin
          shut_now = 1'b1;
        end else if (act_field != ACT_DELAYED) begin
          // A new action byte takes over mid-count instead of waiting it out
          next_r.st = OVF_RUN;
        end else if (pwm_tick) begin
          next_r.dly_cnt = r.dly_cnt + 4'h1;
          if (r.dly_cnt + 4'h1 >= shut_delay) begin
            // Only a fault still present at the end stops switching
            if (fault) begin
              shut_now = 1'b1;
            end else begin
              next_r.st = OVF_RUN;
            end
          end
        end
      end
      OVF_HICCUP: begin
        if (!enable) begin
          next_r.st = OVF_OFF;
        end else if (r.rise_cnt + RISE_W'(1) >= soft_start_rise_time) begin
          next_r.rise_cnt = '0;
          next_r.unit_cnt = r.unit_cnt + 3'h1;
          if (r.unit_cnt + 3'h1 >= hiccup_mult) begin
            next_r.unit_cnt = 3'h0;
            if (retry_field == RETRY_FOREVER || r.attempts < retry_field) begin
              if (retry_field != RETRY_FOREVER) begin
                next_r.attempts = r.attempts + 3'h1;
              end
              if (fault) begin
                // Unseen attempt: wait another hiccup, or give up
                if (retry_field != RETRY_FOREVER && r.attempts + 3'h1 >= retry_field) begin
                  next_r.st = OVF_LATCHED;
                end
              end else begin
                next_r.st       = OVF_START;
                next_r.power_on = 1'b1;
              end
            end else begin
              next_r.st = OVF_LATCHED;
            end
          end
        end else begin
          next_r.rise_cnt = r.rise_cnt + RISE_W'(1);
        end
      end
      OVF_LATCHED: begin
        next_r.power_on = 1'b0;
        // Only a disable frees a latched-off converter
        if (!enable) begin
          next_r.st = OVF_OFF;
        end
      end
      default: begin
        next_r.st       = OVF_OFF;
        next_r.power_on = 1'b0;
      end
    endcase

    // Shutdown entry shared by immediate and delayed responses
    if (shut_now) begin
      next_r.power_on = 1'b0;
      next_r.rise_cnt = '0;
      next_r.unit_cnt = 3'h0;
      if (retry_field == RETRY_LATCH) begin
        next_r.st = OVF_LATCHED;
      end else begin
        next_r.st = OVF_HICCUP;
      end
    end

    // Sticky flags: a new event beats a clear in the same cycle
    if (clear_faults) begin
      next_r.none_above = 1'b0;
      next_r.input_flag = 1'b0;
      next_r.vin_ov     = 1'b0;
      if (!(cmd_valid && cmd_write && next_r.invalid && !r.invalid)) begin
        next_r.invalid = 1'b0;
      end
    end
    if (fault) begin
      next_r.none_above = 1'b1;
      next_r.input_flag = 1'b1;
      next_r.vin_ov     = 1'b1;
    end
    if (cmd_valid && cmd_write && ((cmd_code == CMD_THRESHOLD && !thr_check[8])
        || (cmd_code == CMD_ACTION && cmd_data[ACT_MSB:ACT_LSB] == ACT_UNSUPPORTED))) begin
      next_r.invalid = 1'b1;
    end
    // Alert follows any pending flag
    next_r.alert = next_r.none_above | next_r.invalid;
  end

  // State register; power-up defaults stand in for stored settings
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      r         <= '0;
      r.st      <= OVF_OFF;
      r.thr     <= STEPS_DEFAULT;
      r.nvm_thr <= STEPS_DEFAULT;
      r.action  <= ACTION_DEFAULT;
    end else begin
      r <= next_r;
    end
  end

  // Outputs come straight from the state register
  assign rd_valid            = r.rd_valid;
  assign rd_data             = r.rd_data;
  assign power_stage_on      = r.power_on;
  assign status_none_above   = r.none_above;
  assign status_input        = r.input_flag;
  assign status_vin_ov       = r.vin_ov;
  assign status_invalid_data = r.invalid;
  assign host_alert          = r.alert;
endmodule

// ==== rtl/ovf_pkg.sv ====
package ovf_pkg;
  // Command codes of the two commands held by this block
  localparam logic [7:0]  CMD_THRESHOLD   = 8'h55;
  localparam logic [7:0]  CMD_ACTION      = 8'h56;
  // Threshold word layout; stored value is a count of 0.25 V steps
  localparam int          EXP_MSB         = 15;
  localparam int          EXP_LSB         = 11;
  localparam int          MAN_MSB         = 10;
  localparam logic [4:0]  EXP_READBACK    = 5'h1e;
  localparam logic [6:0]  EXP_TO_STEPS    = 7'h02;
  localparam logic [7:0]  STEPS_MIN       = 8'h14;
  localparam logic [7:0]  STEPS_MAX       = 8'h58;
  localparam logic [7:0]  STEPS_DEFAULT   = 8'h58;
  // Action byte layout and default
  localparam int          ACT_MSB         = 7;
  localparam int          ACT_LSB         = 6;
  localparam int          RETRY_MSB       = 5;
  localparam int          RETRY_LSB       = 3;
  localparam int          DLY_MSB         = 2;
  localparam int          DLY_LSB         = 0;
  localparam logic [7:0]  ACTION_DEFAULT  = 8'h80;
  localparam logic [1:0]  ACT_IGNORE      = 2'h0;
  localparam logic [1:0]  ACT_DELAYED     = 2'h1;
  localparam logic [1:0]  ACT_IMMEDIATE   = 2'h2;
  localparam logic [1:0]  ACT_UNSUPPORTED = 2'h3;
  localparam logic [2:0]  RETRY_LATCH     = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
  // Shutdown delay in switching clocks, by delay field group
  localparam logic [2:0]  DLY_GROUP_MID   = 3'h2;
  localparam logic [2:0]  DLY_GROUP_LONG  = 3'h5;
  localparam logic [3:0]  SHUT_DLY_SHORT  = 4'h3;
  localparam logic [3:0]  SHUT_DLY_MID    = 4'h5;
  localparam logic [3:0]  SHUT_DLY_LONG   = 4'h9;
  localparam logic [2:0]  HICCUP_MIN_MULT = 3'h1;
  localparam int          RISE_W          = 24;

  // Power sequencing states, Gray coded along the usual path
  typedef enum logic [2:0] {
    OVF_OFF     = 3'h0,
    OVF_START   = 3'h1,
    OVF_RUN     = 3'h3,
    OVF_DELAY   = 3'h2,
    OVF_HICCUP  = 3'h6,
    OVF_LATCHED = 3'h7
  } ovf_state_t;
endpackage

// ==== tb/ovf_fault_handler_properties.sv ====
`timescale 1ns/100ps
// Port checker for the fault handler; it shadows only the action byte
module ovf_fault_handler_properties (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Command port
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data,
  // Converter side
  input wire logic        enable,
  input wire logic        pwm_tick,
  input wire logic        power_stage_on,
  input wire logic        status_none_above,
  input wire logic        status_input,
  input wire logic        status_vin_ov,
  input wire logic        status_invalid_data,
  input wire logic        host_alert
);
  import ovf_pkg::*;
  logic       rd_cmd;
  logic [1:0] act;
  logic [2:0] dly;
  logic [3:0] ticks;
  logic [3:0] need;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Reads of the two held commands
  assign rd_cmd = cmd_valid && !cmd_write && cmd_code inside {CMD_THRESHOLD, CMD_ACTION};
  // Shutdown delay for the current delay field
  assign need = (dly >= DLY_GROUP_LONG) ? SHUT_DLY_LONG :
                (dly >= DLY_GROUP_MID) ? SHUT_DLY_MID : SHUT_DLY_SHORT;
  // Action shadow; refused writes must not move it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act <= ACTION_DEFAULT[7:6];
      dly <= ACTION_DEFAULT[2:0];
    end else if (cmd_valid && cmd_write && cmd_code == CMD_ACTION &&
                 cmd_data[7:6] != ACT_UNSUPPORTED) begin
      act <= cmd_data[7:6];
      dly <= cmd_data[2:0];
    end
  end
  // Switching clocks while running flagged; saturates so long runs cannot wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ticks <= 4'h0;
    else if (!power_stage_on) ticks <= 4'h0;
    else if (status_vin_ov && pwm_tick && ticks != 4'hf) ticks <= ticks + 4'h1;
  end
  a_read_answer_next: assert property (rd_cmd |=> rd_valid)
    else $error("read not answered");
  a_answer_has_cause: assert property (rd_valid |-> $past(rd_cmd))
    else $error("answer without read");
  a_word_exp_fixed: assert property (rd_cmd && cmd_code == CMD_THRESHOLD |=>
    rd_data[15:8] == {EXP_READBACK, 3'h0}) else $error("threshold readback form");
  a_byte_upper_zero: assert property (rd_cmd && cmd_code == CMD_ACTION |=>
    rd_data[15:8] == 8'h00) else $error("action readback form");
  a_bad_action_flag: assert property (cmd_valid && cmd_write && cmd_code == CMD_ACTION &&
    cmd_data[7:6] == ACT_UNSUPPORTED |=> status_invalid_data && host_alert)
    else $error("bad action not flagged");
  a_alert_follows_flags: assert property (host_alert == (status_none_above ||
    status_input || status_vin_ov || status_invalid_data)) else $error("alert mismatch");
  a_flags_set_together: assert property ($rose(status_vin_ov) |->
    status_input && status_none_above) else $error("fault flags apart");
  a_immediate_cut: assert property ($rose(status_vin_ov) && $past(power_stage_on) &&
    $past(act) == ACT_IMMEDIATE |-> !power_stage_on) else $error("no immediate cut");
  a_ignore_stays_on: assert property ($past(power_stage_on) && $past(enable) &&
    $past(act) == ACT_IGNORE |-> power_stage_on) else $error("ignore mode stopped");
  a_delay_count: assert property ($fell(power_stage_on) && $past(enable) &&
    $past(act) == ACT_DELAYED |-> $past(ticks) + 4'h1 >= need && $past(ticks) <= need + 4'h1)
    else $error("shutdown delay count");
endmodule

// ==== tb/ovf_host_model.sv ====
`timescale 1ns/100ps
// Host end of the command port: one strobe per command, data scrambled while idle
module ovf_host_model (
  // Clock
  input wire logic        clock,
  // Command port
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_code,
  output logic [15:0]     cmd_data,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_data  = 16'h0000;
  end
  // Called 1 ns after an edge; ends two cycles later so strobes never merge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code  = c;
    cmd_data  = d;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    cmd_data  = ~d; // Stale data is not left on the bus
    q = (rd_valid === 1'b1) ? rd_data : 16'hdead;
    @(posedge clock);
    #1;
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
  import ovf_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, enable = 1'b0, startup_done = 1'b0;
  logic        clear_faults = 1'b0, nvm_store = 1'b0, nvm_restore = 1'b0, pwm_tick = 1'b0;
  logic        cmd_valid, cmd_write, rd_valid, power_stage_on, host_alert;
  logic        status_none_above, status_input, status_vin_ov, status_invalid_data;
  logic [7:0]  cmd_code, s, a;
  logic [7:0]  vin = 8'h28;
  logic [23:0] rise = 24'h000004;
  logic [15:0] cmd_data, rd_data, q;
  logic [15:0] bad [4] = '{16'hf013, 16'hf059, 16'he851, 16'hf7d8};
  logic [2:0]  dl [3] = '{3'h1, 3'h3, 3'h6};
  int          n_fail = 0, compares = 0, seed = 27, k, n;
  // 10 MHz clock; switching clock at half that rate
  always #50 clock = ~clock;
  always @(posedge clock) #1 pwm_tick = ~pwm_tick;
  ovf_host_model ovf_host_model_i (.clock, .cmd_valid, .cmd_write, .cmd_code, .cmd_data,
    .rd_valid, .rd_data);
  ovf_fault_handler ovf_fault_handler_i (.clock, .rst_n, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_data, .rd_valid, .rd_data, .enable, .startup_done, .clear_faults, .nvm_store,
    .nvm_restore, .pwm_tick, .soft_start_rise_time(rise),
    .power_stage_input_voltage(vin), .power_stage_on, .status_none_above, .status_input,
    .status_vin_ov, .status_invalid_data, .host_alert);
  // Expected readback of a threshold held as steps
  function automatic logic [15:0] thr_word(input logic [7:0] st);
    return {EXP_READBACK, 3'h0, st};
  endfunction
  // Hiccup length in rise times
  function automatic int hic_mult(input logic [2:0] d);
    return (d < 3'h2) ? 1 : int'(d);
  endfunction
  // Shutdown delay in switching clocks for a delay field
  function automatic int shut_clk(input logic [2:0] d);
    return (d < 3'h2) ? 3 : (d < 3'h5) ? 5 : 9;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    ovf_host_model_i.xfer(1'b1, c, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp, input string what);
    ovf_host_model_i.xfer(1'b0, c, 16'h0000, q);
    check(q, exp, what);
  endtask
  task automatic pulse_clear();
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(1);
  endtask
  // Bounded wait for the power stage to reach a level
  task automatic wait_pwr(input logic v, input int lim);
    n = 0;
    while (power_stage_on !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic start(input logic [7:0] act);
    wr(CMD_ACTION, {8'h00, act});
    enable = 1'b1;
    cyc(3);
    check(16'(power_stage_on), 16'h1, "started");
    vin = 8'h3c; // Above the 12 V threshold
  endtask
  task automatic stop(input string t);
    vin = 8'h28;
    enable = 1'b0;
    cyc(2);
    pulse_clear();
    $display("test %s done", t);
  endtask
  initial begin
    cyc(3);
    rst_n = 1'b1;
    startup_done = 1'b1;
    cyc(3);
    rd_chk(CMD_THRESHOLD, thr_word(STEPS_DEFAULT), "thr reset");
    rd_chk(CMD_ACTION, {8'h00, ACTION_DEFAULT}, "act reset");
    // Range ends first, then random steps in both exponent forms
    for (k = 0; k < 8; k++) begin
      s = (k == 0) ? STEPS_MIN : (k == 1) ? STEPS_MAX : 8'(20 + {$random(seed)} % 69);
      wr(CMD_THRESHOLD, s[0] ? thr_word(s) : {5'h1f, 4'h0, s[7:1]});
      rd_chk(CMD_THRESHOLD, thr_word(s), "thr write");
    end
    foreach (bad[i]) begin
      pulse_clear();
      wr(CMD_THRESHOLD, bad[i]);
      check(16'(status_invalid_data && host_alert), 16'h1, "thr refused");
      rd_chk(CMD_THRESHOLD, thr_word(s), "thr kept");
    end
    for (k = 0; k < 3; k++) begin
      a = {k[1:0], 6'({$random(seed)})};
      wr(CMD_ACTION, {8'h00, a});
      rd_chk(CMD_ACTION, {8'h00, a}, "act write");
    end
    pulse_clear();
    wr(CMD_ACTION, 16'h00c5);
    check(16'(status_invalid_data), 16'h1, "act refused");
    rd_chk(CMD_ACTION, {8'h00, a}, "act kept");
    wr(CMD_THRESHOLD, thr_word(8'h30));
    nvm_store = 1'b1;
    cyc(1);
    nvm_store = 1'b0;
    wr(CMD_THRESHOLD, thr_word(8'h20));
    nvm_restore = 1'b1;
    cyc(1);
    nvm_restore = 1'b0;
    cyc(1);
    rd_chk(CMD_THRESHOLD, thr_word(8'h30), "restore");
    pulse_clear();
    $display("test registers done");
    start(8'h00);
    cyc(20);
    check(16'({power_stage_on, status_none_above, status_input, status_vin_ov, host_alert}),
          16'h1f, "ignore");
    // Fault still present, so the clear must lose to the set
    pulse_clear();
    check(16'({status_vin_ov, host_alert}), 16'h3, "set beats clear");
    enable = 1'b0;
    cyc(3);
    enable = 1'b1;
    cyc(5);
    check(16'(power_stage_on), 16'h0, "start blocked");
    stop("ignore");
    start(8'h80);
    cyc(2);
    check(16'(power_stage_on), 16'h0, "cut");
    vin = 8'h28;
    cyc(40);
    check(16'(power_stage_on), 16'h0, "latched");
    stop("latch");
    start(8'h90);
    cyc(30);
    vin = 8'h28;
    cyc(40);
    check(16'(power_stage_on), 16'h0, "retries spent");
    stop("retry");
    // Delayed cut with endless retry; fault removed after the cut, so the first retry
    // restarts; switching ticks come every other cycle, rise time is drawn at random
    foreach (dl[i]) begin
      rise = 24'(2 + {$random(seed)} % 4);
      start({5'h0f, dl[i]});
      wait_pwr(1'b0, 60);
      k = 2 * shut_clk(dl[i]);
      check(16'(n >= k && n <= k + 1), 16'h1, "delayed cut");
      vin = 8'h28;
      wait_pwr(1'b1, 100);
      k = int'(rise) * hic_mult(dl[i]);
      check(16'(n >= k - 1 && n <= k + 1), 16'h1, "hiccup");
      stop("delayed");
    end
    complete_run();
  end
  // Run needs under 1000 cycles; cut off at 10000
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end
endmodule
bind ovf_fault_handler ovf_fault_handler_properties ovf_fault_handler_properties_i (.clock,
  .rst_n, .cmd_valid, .cmd_write, .cmd_code, .cmd_data, .rd_valid, .rd_data, .enable, .pwm_tick,
  .power_stage_on, .status_none_above, .status_input, .status_vin_ov, .status_invalid_data,
  .host_alert);
